// ### pmw_pkg.sv
package pmw_pkg;
   // register byte offsets
   localparam logic [7:0] PMW_CTRL_OFF = 8'h00;
   localparam logic [7:0] PMW_FUNC_OFF = 8'h04;
   localparam logic [7:0] PMW_STAT_OFF = 8'h08;
   localparam logic [7:0] PMW_CMD_OFF = 8'h0C;
   // control field positions
   localparam int PMW_CTRL_SCLK_BIT = 0;
   localparam int PMW_CTRL_USB_HOST_BIT = 1;
   localparam int PMW_CTRL_SUSP_BIT = 2;
   localparam int PMW_CTRL_RWAKE_BIT = 3;
   localparam int PMW_CTRL_COMBINED_BIT = 4;
   localparam int PMW_CTRL_REPORT_BIT = 5;
   localparam int PMW_CTRL_BACKUP_BIT = 6;
   localparam int PMW_CTRL_ACQ_DONE_BIT = 7;
   localparam int PMW_CTRL_CELL_EN_BIT = 8;
   // functionality level codes
   localparam logic [2:0] PMW_FUN_MIN = 3'h0;
   localparam logic [2:0] PMW_FUN_FULL = 3'h1;
   localparam logic [2:0] PMW_FUN_AIR = 3'h4;
   // reset values
   localparam logic [8:0] PMW_CTRL_RST = 9'h100;
   localparam logic [2:0] PMW_FUNC_RST = 3'h1;
   // axi responses
   localparam logic [1:0] PMW_RESP_OKAY = 2'h0;
   localparam logic [1:0] PMW_RESP_SLVERR = 2'h2;
   // pulse length of the ring line, in cycles
   localparam int PMW_RING_CYC = 16;
   // positioning part states, gray along the usual path
   typedef enum logic [1:0]
   {
      PMW_POS_OFF = 2'h0,
      PMW_POS_ACQ = 2'h1,
      PMW_POS_TRK = 2'h3,
      PMW_POS_BKP = 2'h2
   } pmw_pos_t;
endpackage

// ### pmw_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for pin levels
module pmw_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
)
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // level in and out
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   typedef struct packed
   {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } pmw_sync_t;
   pmw_sync_t st_q;
   pmw_sync_t st_d;
   // refused at elaboration: a zero-width synchroniser has nothing to carry
   if (W < 1)
   begin
      $error("width must be positive");
   end
   // first stage only feeds the second
   always_comb
   begin
      st_d.s1 = din;
      st_d.s2 = st_q.s1;
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q <= {INIT, INIT};
      end
      else
      begin
         st_q <= st_d;
      end
   end
   assign dout = st_q.s2;
endmodule

// ### pmw_pos_fsm.sv
`timescale 1ns/1ps
// positioning part mode sequencer
module pmw_pos_fsm
   import pmw_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // conditions
   input wire logic run_ok,
   input wire logic backup_req,
   input wire logic acq_done,
   // state
   output pmw_pkg::pmw_pos_t state
);
   typedef struct packed
   {
      pmw_pos_t st;
   } pmw_pfs_t;
   pmw_pfs_t st_q;
   pmw_pfs_t st_d;
   // enter acquisition once powered (backup instead if backup_req is set), then tracking
   always_comb
   begin
      st_d = st_q;
      unique case (st_q.st)
         PMW_POS_OFF:
         begin
            if (run_ok)
            begin
               st_d.st = backup_req ? PMW_POS_BKP : PMW_POS_ACQ;
            end
         end
         PMW_POS_ACQ:
         begin
            if (!run_ok)
            begin
               st_d.st = PMW_POS_OFF;
            end
            else if (backup_req)
            begin
               st_d.st = PMW_POS_BKP;
            end
            else if (acq_done)
            begin
               st_d.st = PMW_POS_TRK;
            end
         end
         PMW_POS_TRK:
         begin
            if (!run_ok)
            begin
               st_d.st = PMW_POS_OFF;
            end
            else if (backup_req)
            begin
               st_d.st = PMW_POS_BKP;
            end
         end
         PMW_POS_BKP:
         begin
            // restart with acquisition; saved data shortens it
            if (!run_ok)
            begin
               st_d.st = PMW_POS_OFF;
            end
            else if (!backup_req)
            begin
               st_d.st = PMW_POS_ACQ;
            end
         end
      endcase
   end
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q.st <= PMW_POS_OFF;
      end
      else
      begin
         st_q <= st_d;
      end
   end
   assign state = st_q.st;
endmodule

// ### pmw_power_mode_wake.sv
// Notes on behaviour
// - uart sleep needs sclk=1 and dtr high
// - dtr low wakes the device
// - pending report pulses ring line (uart)
// - usb suspend host also needs bus suspended
// - usb data from host wakes device
// - remote-wake host gets usb resume signalling
// - suspend without remote wake uses ring line
// - no-suspend host: vbus off sleeps, on wakes
// - radio-disable pin pulled high; low means airplane
// - airplane refuses rf-related commands
// - fun 0 min, 1 full default, 4 airplane
// - paging and data still received asleep
// - positioning runs when enable and backup present
// - acquisition first, then tracking
// - backup mode keeps navigation data
// - combined: positioning off when cellular off
// - combined: positioning uart cut from pins
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
module pmw_power_mode_wake
   import pmw_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // host-facing pins, asynchronous
   input wire logic terminal_ready,
   input wire logic usb_bus_power_sense,
   input wire logic usb_suspended,
   input wire logic usb_host_traffic,
   input wire logic radio_disable_n,
   input wire logic positioning_power_enable,
   input wire logic positioning_backup_supply,
   // wake and mode outputs
   output logic ring_indicator_line,
   output logic usb_remote_wake,
   output logic sleep_active,
   output logic rf_enable,
   output logic sim_enable,
   output logic positioning_rf_enable,
   output logic positioning_system_supply,
   output logic positioning_uart_connect
);
   typedef struct packed
   {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [8:0] ctrl;
      logic [2:0] fun;
      logic cmd_refused;
      logic cmd_done;
      logic asleep;
      logic ring;
      logic [4:0] ring_cnt;
      logic rwake;
      logic vbus_prev;
      logic rf_en;
      logic sim_en;
      logic pos_rf;
      logic pos_sup;
      logic pos_uart;
   } pmw_top_t;
   pmw_top_t st_q;
   pmw_top_t st_d;
   logic [6:0] pins_raw;
   logic [6:0] pins_s;
   logic dtr_s;
   logic vbus_s;
   logic susp_s;
   logic traf_s;
   logic wdis_n_s;
   logic pen_s;
   logic bkp_s;
   logic sleep_ok;
   logic wake_ev;
   logic report;
   logic airplane;
   logic pos_run_ok;
   pmw_pos_t pos_state;
   logic wr_fire;
   logic rd_fire;
   logic [31:0] wmask;

   // byte-lane mask from write strobes
   function automatic logic [31:0] lane_mask(input logic [3:0] strb);
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 4; i++)
      begin
         m[i*8 +: 8] = {8{strb[i]}};
      end
      return m;
   endfunction

   // decode of a mapped register offset, used by both channels
   function automatic logic addr_mapped(input logic [7:0] a);
      return (a == PMW_CTRL_OFF) || (a == PMW_FUNC_OFF) || (a == PMW_STAT_OFF) || (a == PMW_CMD_OFF);
   endfunction

   // all pins pass two flops; the pad pull-up is modelled by pin reset value high
   assign pins_raw = {terminal_ready, usb_bus_power_sense, usb_suspended, usb_host_traffic,
                      radio_disable_n, positioning_power_enable, positioning_backup_supply};
   pmw_sync #(
      .W(7),
      .INIT(7'h44)
   ) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(pins_raw),
      .dout(pins_s)
   );
   assign dtr_s = pins_s[6];
   assign vbus_s = pins_s[5];
   assign susp_s = pins_s[4];
   assign traf_s = pins_s[3];
   assign wdis_n_s = pins_s[2];
   assign pen_s = pins_s[1];
   assign bkp_s = pins_s[0];

   // positioning may run only while its own supplies are present
   assign pos_run_ok = pen_s && bkp_s && (!st_q.ctrl[PMW_CTRL_COMBINED_BIT] || st_q.ctrl[PMW_CTRL_CELL_EN_BIT]);
   pmw_pos_fsm u_pos (
      .aclk(aclk),
      .aresetn(aresetn),
      .run_ok(pos_run_ok),
      .backup_req(st_q.ctrl[PMW_CTRL_BACKUP_BIT]),
      .acq_done(st_q.ctrl[PMW_CTRL_ACQ_DONE_BIT]),
      .state(pos_state)
   );

   // sleep eligibility per host kind
   always_comb
   begin
      sleep_ok = st_q.ctrl[PMW_CTRL_SCLK_BIT] && dtr_s;
      if (st_q.ctrl[PMW_CTRL_USB_HOST_BIT])
      begin
         if (st_q.ctrl[PMW_CTRL_SUSP_BIT])
         begin
            sleep_ok = sleep_ok && susp_s;
         end
         else
         begin
            sleep_ok = sleep_ok && !vbus_s;
         end
      end
   end

   // wake sources; vbus return is an edge so it does not re-block sleep later
   assign wake_ev = !dtr_s
                    || (st_q.ctrl[PMW_CTRL_USB_HOST_BIT] && st_q.ctrl[PMW_CTRL_SUSP_BIT] && traf_s)
                    || (st_q.ctrl[PMW_CTRL_USB_HOST_BIT] && !st_q.ctrl[PMW_CTRL_SUSP_BIT]
                        && vbus_s && !st_q.vbus_prev);
   assign report = st_q.ctrl[PMW_CTRL_REPORT_BIT];
   assign airplane = !wdis_n_s || (st_q.fun == PMW_FUN_AIR);
   assign wr_fire = st_q.aw_got && st_q.w_got && !st_q.bvalid;
   assign rd_fire = s_axi_arvalid && !st_q.rvalid;
   assign wmask = lane_mask(st_q.w_strb);

   // next state of bus slave and mode logic
   always_comb
   begin
      st_d = st_q;
      st_d.vbus_prev = vbus_s;
      // write address and data taken in either order
      if (s_axi_awvalid && !st_q.aw_got)
      begin
         st_d.aw_got = 1'b1;
         st_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_q.w_got)
      begin
         st_d.w_got = 1'b1;
         st_d.w_data = s_axi_wdata;
         st_d.w_strb = s_axi_wstrb;
      end
      if (st_q.bvalid && s_axi_bready)
      begin
         st_d.bvalid = 1'b0;
      end
      if (wr_fire)
      begin
         st_d.aw_got = 1'b0;
         st_d.w_got = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = addr_mapped(st_q.aw_addr) ? PMW_RESP_OKAY : PMW_RESP_SLVERR;
         unique case (st_q.aw_addr)
            PMW_CTRL_OFF:
            begin
               st_d.ctrl = 9'((st_q.ctrl & ~wmask[8:0]) | (st_q.w_data[8:0] & wmask[8:0]));
            end
            PMW_FUNC_OFF:
            begin
               // only the three documented levels are accepted
               if (wmask[0] && (st_q.w_data[2:0] == PMW_FUN_MIN || st_q.w_data[2:0] == PMW_FUN_FULL
                                || st_q.w_data[2:0] == PMW_FUN_AIR))
               begin
                  st_d.fun = st_q.w_data[2:0];
               end
               else
               begin
                  st_d.bresp = PMW_RESP_SLVERR;
               end
            end
            PMW_CMD_OFF:
            begin
               // bit0 flags an rf-related command; refused in airplane or minimum mode
               st_d.cmd_refused = st_q.w_data[0] && (airplane || st_q.fun == PMW_FUN_MIN);
               st_d.cmd_done = !st_d.cmd_refused;
               if (st_d.cmd_refused)
               begin
                  st_d.bresp = PMW_RESP_SLVERR;
               end
            end
            default:
            begin
               st_d.ctrl = st_q.ctrl;
            end
         endcase
      end
      // read channel, one cycle to answer
      if (st_q.rvalid && s_axi_rready)
      begin
         st_d.rvalid = 1'b0;
      end
      if (rd_fire)
      begin
         st_d.rvalid = 1'b1;
         st_d.rresp = addr_mapped(s_axi_araddr) ? PMW_RESP_OKAY : PMW_RESP_SLVERR;
         unique case (s_axi_araddr)
            PMW_CTRL_OFF: st_d.rdata = {23'h0, st_q.ctrl};
            PMW_FUNC_OFF: st_d.rdata = {29'h0, st_q.fun};
            PMW_STAT_OFF: st_d.rdata = {20'h0, st_q.cmd_done, st_q.cmd_refused, pos_state, st_q.pos_uart,
                                        st_q.pos_sup, st_q.pos_rf, st_q.sim_en, st_q.rf_en, st_q.rwake,
                                        st_q.ring, st_q.asleep};
            default: st_d.rdata = 32'h0;
         endcase
      end
      // sleep entry and exit; wake wins over entry in the same cycle
      if (wake_ev)
      begin
         st_d.asleep = 1'b0;
      end
      else if (sleep_ok)
      begin
         st_d.asleep = 1'b1;
      end
      // host wake for pending report
      st_d.rwake = 1'b0;
      if (st_q.ring_cnt != 5'h0)
      begin
         st_d.ring_cnt = st_q.ring_cnt - 5'h1;
      end
      if (report && st_q.ctrl[PMW_CTRL_USB_HOST_BIT] && st_q.ctrl[PMW_CTRL_SUSP_BIT]
          && st_q.ctrl[PMW_CTRL_RWAKE_BIT])
      begin
         st_d.rwake = susp_s;
      end
      else if (report && st_q.ring_cnt == 5'h0 && !st_q.ring)
      begin
         st_d.ring_cnt = 5'(PMW_RING_CYC);
      end
      st_d.ring = (st_d.ring_cnt != 5'h0);
      // rf follows the level and the pin, sim the level only; receive kept while asleep
      st_d.rf_en = !airplane && (st_q.fun != PMW_FUN_MIN);
      st_d.sim_en = (st_q.fun != PMW_FUN_MIN);
      st_d.pos_rf = (pos_state == PMW_POS_ACQ) || (pos_state == PMW_POS_TRK);
      st_d.pos_sup = pos_run_ok;
      st_d.pos_uart = !st_q.ctrl[PMW_CTRL_COMBINED_BIT];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q <= '0;
         st_q.ctrl <= PMW_CTRL_RST;
         st_q.fun <= PMW_FUNC_RST;
         st_q.vbus_prev <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // outputs straight from flops
   assign s_axi_awready = !st_q.aw_got;
   assign s_axi_wready = !st_q.w_got;
   assign s_axi_bvalid = st_q.bvalid;
   assign s_axi_bresp = st_q.bresp;
   assign s_axi_arready = !st_q.rvalid;
   assign s_axi_rvalid = st_q.rvalid;
   assign s_axi_rdata = st_q.rdata;
   assign s_axi_rresp = st_q.rresp;
   assign ring_indicator_line = st_q.ring;
   assign usb_remote_wake = st_q.rwake;
   assign sleep_active = st_q.asleep;
   assign rf_enable = st_q.rf_en;
   assign sim_enable = st_q.sim_en;
   assign positioning_rf_enable = st_q.pos_rf;
   assign positioning_system_supply = st_q.pos_sup;
   assign positioning_uart_connect = st_q.pos_uart;

   // sleep never entered without the command
   property p_no_sleep_wo_cmd;
      @(posedge aclk) disable iff (!aresetn)
      $rose(st_q.asleep) |-> $past(st_q.ctrl[PMW_CTRL_SCLK_BIT]) && $past(dtr_s);
   endproperty
   a_no_sleep_wo_cmd: assert property (p_no_sleep_wo_cmd) else $error("sleep without command");
   // dtr low leaves sleep next cycle
   property p_dtr_wake;
      @(posedge aclk) disable iff (!aresetn)
      !dtr_s |=> !st_q.asleep;
   endproperty
   a_dtr_wake: assert property (p_dtr_wake) else $error("dtr low did not wake");
   // report starts ring in uart mode within two cycles
   sequence s_report_uart;
      report && !st_q.ctrl[PMW_CTRL_USB_HOST_BIT];
   endsequence
   property p_ring;
      @(posedge aclk) disable iff (!aresetn)
      s_report_uart |-> ##[1:2] ring_indicator_line;
   endproperty
   a_ring: assert property (p_ring) else $error("ring not raised");
   // usb suspend host: no sleep while bus active
   property p_usb_susp;
      @(posedge aclk) disable iff (!aresetn)
      $rose(st_q.asleep) && $past(st_q.ctrl[PMW_CTRL_USB_HOST_BIT] && st_q.ctrl[PMW_CTRL_SUSP_BIT]) |-> $past(susp_s);
   endproperty
   a_usb_susp: assert property (p_usb_susp) else $error("slept with bus active");
   // usb traffic wakes
   property p_traffic;
      @(posedge aclk) disable iff (!aresetn)
      traf_s && st_q.ctrl[PMW_CTRL_USB_HOST_BIT] && st_q.ctrl[PMW_CTRL_SUSP_BIT] |=> !st_q.asleep;
   endproperty
   a_traffic: assert property (p_traffic) else $error("traffic did not wake");
   // airplane disables rf
   property p_air;
      @(posedge aclk) disable iff (!aresetn)
      !wdis_n_s |=> !rf_enable;
   endproperty
   a_air: assert property (p_air) else $error("rf on in airplane");
   // minimum level drops sim
   property p_min;
      @(posedge aclk) disable iff (!aresetn)
      st_q.fun == PMW_FUN_MIN |=> !sim_enable && !rf_enable;
   endproperty
   a_min: assert property (p_min) else $error("sim on at minimum");
   // combined configuration isolates uart and follows cellular
   property p_comb;
      @(posedge aclk) disable iff (!aresetn)
      st_q.ctrl[PMW_CTRL_COMBINED_BIT] && !st_q.ctrl[PMW_CTRL_CELL_EN_BIT] |=> !positioning_uart_connect && !positioning_system_supply;
   endproperty
   a_comb: assert property (p_comb) else $error("combined isolation broken");
endmodule

// ### pmw_host_model.sv
`timescale 1ns/1ps
// host side of the pin interface: drives levels, times the ring line
module pmw_host_model
(
   // clock
   input wire logic aclk,
   // wake line from the device
   input wire logic ring_indicator_line,
   // pin levels towards the device
   output logic terminal_ready,
   output logic usb_bus_power_sense,
   output logic usb_suspended,
   output logic usb_host_traffic,
   output logic radio_disable_n,
   output logic positioning_power_enable,
   output logic positioning_backup_supply
);
   int ring_pulses;
   int ring_len;
   int ring_run;

   // idle levels: pulled-up lines sit high, positioning pins low
   initial
   begin
      terminal_ready = 1'b1;
      usb_bus_power_sense = 1'b1;
      usb_suspended = 1'b0;
      usb_host_traffic = 1'b0;
      radio_disable_n = 1'b1;
      positioning_power_enable = 1'b0;
      positioning_backup_supply = 1'b0;
      ring_pulses = 0;
      ring_len = 0;
      ring_run = 0;
   end

   // all pins change together just after an edge, never mid-cycle
   // order: dtr, vbus, suspend, traffic, radio_disable_n, enable, backup
   task automatic drive(input logic [6:0] v);
      @(posedge aclk);
      {terminal_ready, usb_bus_power_sense, usb_suspended, usb_host_traffic} <= v[6:3];
      {radio_disable_n, positioning_power_enable, positioning_backup_supply} <= v[2:0];
   endtask

   // width of the last ring pulse, in cycles, and the number of pulses seen
   always @(posedge aclk)
   begin
      if (ring_indicator_line === 1'b1)
         ring_run <= ring_run + 1;
      else if (ring_run != 0)
      begin
         ring_len <= ring_run;
         ring_pulses <= ring_pulses + 1;
         ring_run <= 0;
      end
   end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import pmw_pkg::*;
   localparam logic [31:0] SCLK = 32'h1 << PMW_CTRL_SCLK_BIT;
   localparam logic [31:0] USB = 32'h1 << PMW_CTRL_USB_HOST_BIT;
   localparam logic [31:0] SUSP = 32'h1 << PMW_CTRL_SUSP_BIT;
   localparam logic [31:0] RWK = 32'h1 << PMW_CTRL_RWAKE_BIT;
   localparam logic [31:0] COMB = 32'h1 << PMW_CTRL_COMBINED_BIT;
   localparam logic [31:0] REP = 32'h1 << PMW_CTRL_REPORT_BIT;
   localparam logic [31:0] BKR = 32'h1 << PMW_CTRL_BACKUP_BIT;
   localparam logic [31:0] ACQ = 32'h1 << PMW_CTRL_ACQ_DONE_BIT;
   localparam logic [31:0] CELL = 32'h1 << PMW_CTRL_CELL_EN_BIT;
   localparam logic [2:0] LVL [3] = '{PMW_FUN_MIN, PMW_FUN_AIR, PMW_FUN_FULL};
   // generous: the whole sequence needs well under 3000 cycles
   localparam int LIMIT = 20000;
   logic aclk, aresetn;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic terminal_ready, usb_bus_power_sense, usb_suspended, usb_host_traffic, radio_disable_n;
   logic positioning_power_enable, positioning_backup_supply, ring_indicator_line, usb_remote_wake;
   logic sleep_active, rf_enable, sim_enable, positioning_rf_enable, positioning_system_supply;
   logic positioning_uart_connect;
   int err_total, compares, cyc, n;

   pmw_power_mode_wake u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .terminal_ready, .usb_bus_power_sense, .usb_suspended,
      .usb_host_traffic, .radio_disable_n, .positioning_power_enable, .positioning_backup_supply,
      .ring_indicator_line, .usb_remote_wake, .sleep_active, .rf_enable, .sim_enable,
      .positioning_rf_enable, .positioning_system_supply, .positioning_uart_connect);

   pmw_host_model u_host (.aclk, .ring_indicator_line, .terminal_ready, .usb_bus_power_sense,
      .usb_suspended, .usb_host_traffic, .radio_disable_n, .positioning_power_enable,
      .positioning_backup_supply);

   // clock, 8 ns period
   initial
   begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end

   // hang guard, counts a mismatch before closing
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (cyc == LIMIT)
      begin
         err_total++;
         summarize();
      end
   end

   task automatic summarize;
      $display("mismatches %0d, compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic chk1(input logic seen, input logic exp);
      check({31'h0, seen}, {31'h0, exp});
   endtask

   // write: address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ad;
      logic wd;
      ad = 1'b0;
      wd = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(ad && wd))
      begin
         @(posedge aclk);
         if (!ad && s_axi_awready === 1'b1)
         begin
            ad = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!wd && s_axi_wready === 1'b1)
         begin
            wd = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      check({30'h0, s_axi_bresp}, {30'h0, er});
   endtask

   // read, then compare the masked word and the response
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid !== 1'b1)
         do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      check(s_axi_rdata & m, ed);
      check({30'h0, s_axi_rresp}, {30'h0, er});
   endtask

   // pins need two edges through the synchronisers and one more to the outputs; margin on top
   task automatic settle;
      repeat (8) @(posedge aclk);
   endtask

   // main sequence
   initial
   begin
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {err_total, compares, cyc} = '0;
      aresetn = 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rd(PMW_CTRL_OFF, 32'(PMW_CTRL_RST), 32'hFFFFFFFF, PMW_RESP_OKAY);
      rd(PMW_FUNC_OFF, 32'(PMW_FUNC_RST), 32'hFFFFFFFF, PMW_RESP_OKAY);
      rd(8'h10, 32'h0, 32'hFFFFFFFF, PMW_RESP_SLVERR);
      chk1(rf_enable, 1'b1);
      // uart host: sleep needs the clock command and dtr high
      wr(PMW_CTRL_OFF, CELL, PMW_RESP_OKAY);
      settle;
      chk1(sleep_active, 1'b0);
      wr(PMW_CTRL_OFF, CELL | SCLK, PMW_RESP_OKAY);
      settle;
      chk1(sleep_active, 1'b1);
      u_host.drive(7'b0100100);
      settle;
      chk1(sleep_active, 1'b0);
      u_host.drive(7'b1100100);
      wr(PMW_CTRL_OFF, CELL | SCLK | REP, PMW_RESP_OKAY);
      repeat (40) @(posedge aclk);
      check(32'(u_host.ring_len), 32'(PMW_RING_CYC));
      // usb host with suspend: bus state gates sleep, traffic wakes
      u_host.drive(7'b0100100);
      wr(PMW_CTRL_OFF, CELL | SCLK | USB | SUSP, PMW_RESP_OKAY);
      u_host.drive(7'b1100100);
      settle;
      chk1(sleep_active, 1'b0);
      u_host.drive(7'b1110100);
      settle;
      chk1(sleep_active, 1'b1);
      u_host.drive(7'b1111100);
      settle;
      chk1(sleep_active, 1'b0);
      u_host.drive(7'b1110100);
      wr(PMW_CTRL_OFF, CELL | SCLK | USB | SUSP | RWK | REP, PMW_RESP_OKAY);
      settle;
      n = u_host.ring_pulses;
      chk1(usb_remote_wake, 1'b1);
      repeat (40) @(posedge aclk);
      check(32'(u_host.ring_pulses), 32'(n));
      wr(PMW_CTRL_OFF, CELL | SCLK | USB | SUSP | REP, PMW_RESP_OKAY);
      repeat (40) @(posedge aclk);
      chk1(usb_remote_wake, 1'b0);
      chk1(u_host.ring_pulses > n, 1'b1);
      // usb host without suspend: bus power off sleeps, back on wakes
      u_host.drive(7'b0100100);
      wr(PMW_CTRL_OFF, CELL | SCLK | USB, PMW_RESP_OKAY);
      u_host.drive(7'b1000100);
      settle;
      chk1(sleep_active, 1'b1);
      u_host.drive(7'b1100100);
      settle;
      chk1(sleep_active, 1'b0);
      // radio-disable pin
      u_host.drive(7'b1100000);
      settle;
      chk1(rf_enable, 1'b0);
      chk1(sim_enable, 1'b1);
      wr(PMW_CMD_OFF, 32'h1, PMW_RESP_SLVERR);
      u_host.drive(7'b1100100);
      settle;
      chk1(rf_enable, 1'b1);
      wr(PMW_CMD_OFF, 32'h1, PMW_RESP_OKAY);
      // every functionality level, then an undefined one
      for (int i = 0; i < 3; i++)
      begin
         wr(PMW_FUNC_OFF, 32'(LVL[i]), PMW_RESP_OKAY);
         settle;
         rd(PMW_FUNC_OFF, 32'(LVL[i]), 32'h7, PMW_RESP_OKAY);
         chk1(rf_enable, LVL[i] == PMW_FUN_FULL);
         chk1(sim_enable, LVL[i] != PMW_FUN_MIN);
         wr(PMW_CMD_OFF, 32'h1, (LVL[i] == PMW_FUN_FULL) ? PMW_RESP_OKAY : PMW_RESP_SLVERR);
      end
      wr(PMW_FUNC_OFF, 32'h2, PMW_RESP_SLVERR);
      s_axi_wstrb <= 4'hE;
      wr(PMW_FUNC_OFF, 32'h4, PMW_RESP_SLVERR);
      s_axi_wstrb <= 4'hF;
      rd(PMW_FUNC_OFF, 32'(PMW_FUN_FULL), 32'h7, PMW_RESP_OKAY);
      // positioning part, standalone
      wr(PMW_CTRL_OFF, CELL, PMW_RESP_OKAY);
      u_host.drive(7'b1100111);
      settle;
      chk1(positioning_rf_enable, 1'b1);
      rd(PMW_STAT_OFF, 32'(PMW_POS_ACQ) << 8, 32'h300, PMW_RESP_OKAY);
      chk1(positioning_uart_connect, 1'b1);
      wr(PMW_CTRL_OFF, CELL | ACQ, PMW_RESP_OKAY);
      settle;
      rd(PMW_STAT_OFF, 32'(PMW_POS_TRK) << 8, 32'h300, PMW_RESP_OKAY);
      wr(PMW_CTRL_OFF, CELL | ACQ | BKR, PMW_RESP_OKAY);
      settle;
      rd(PMW_STAT_OFF, 32'(PMW_POS_BKP) << 8, 32'h300, PMW_RESP_OKAY);
      chk1(positioning_rf_enable, 1'b0);
      // combined: cellular off holds positioning off, uart cut
      wr(PMW_CTRL_OFF, COMB, PMW_RESP_OKAY);
      settle;
      rd(PMW_STAT_OFF, 32'(PMW_POS_OFF) << 8, 32'h300, PMW_RESP_OKAY);
      chk1(positioning_uart_connect, 1'b0);
      wr(PMW_CTRL_OFF, COMB | CELL, PMW_RESP_OKAY);
      settle;
      chk1(positioning_rf_enable, 1'b1);
      // standalone keeps running with cellular off
      wr(PMW_CTRL_OFF, 32'h0, PMW_RESP_OKAY);
      settle;
      chk1(positioning_rf_enable, 1'b1);
      chk1(positioning_uart_connect, 1'b1);
      u_host.drive(7'b1100100);
      settle;
      chk1(positioning_rf_enable, 1'b0);
      chk1(positioning_system_supply, 1'b0);
      summarize();
   end
endmodule
